// ---- src/scb_exception_dispatch.sv ----
// exception and interrupt dispatch through the vector table
// Functional notes
// - bad mode field 101/110/111 on event entry halts with code 19/1a/1b
// - bad mode field 101/110/111 restored by return halts with code 1d/1e/1f
// - vector table base held in internal register 17; vectors are aligned longwords
// - service address is vector bits 31:2 with two low bits forced zero
// - code 00 services on kernel stack unless already on interrupt stack
// - code 01 uses interrupt stack; exceptions raise priority level to 1f
// - codes 10 and 11 are unimplemented and cause a console error halt
// - passive release at offset 00 raises priority to the requested level
// - machine check uses offset 04, six parameters, interrupt stack
// - kernel stack invalid uses offset 08, no parameters, interrupt stack
// - power fail uses offset 0c, no parameters, priority level 1e
// - access violation and translation invalid use 20 and 24, two parameters
// - arithmetic uses offset 34 with one type code parameter
// - change mode traps use 40 to 4c with one sign-extended operand
// - software levels 4-15 from offset 90; levels 1-3 at 84, 88, 8c
// - emulation start uses c8, same mode, first part done clear, ten parameters
// - emulation continue uses cc, same mode, first part done set, no parameters
// - in 30-bit addressing mode process base bits 31:30 are ignored
// - process context load flushes only process-space translation entries
// - machine check during machine check processing halts with code 12
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
module scb_exception_dispatch
  import scb_dispatch_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // event request from the cpu core
  input wire logic ev_valid,
  input wire event_kind_t ev_kind,
  input wire logic ev_is_exception,
  input wire logic [4:0] ev_req_prio,
  input wire logic [3:0] ev_level,
  input wire logic [1:0] ev_chm_sel,
  // return from exception
  input wire logic ret_valid,
  input wire logic [31:0] ret_psw,
  // process context load
  input wire logic ldctx_valid,
  // vector fetch memory port
  output logic vfetch_req,
  output logic [31:0] vfetch_addr,
  input wire logic vfetch_ack,
  input wire logic [31:0] vfetch_data,
  // dispatch result
  output logic disp_valid,
  output logic [31:0] disp_pc,
  output logic disp_on_intstk,
  output logic disp_same_mode,
  output logic disp_fpd,
  output logic [4:0] disp_prio,
  output logic [3:0] disp_nparams,
  output logic [31:0] disp_psw,
  output logic busy,
  // console halt
  output logic halt,
  output logic [5:0] halt_code,
  // translation buffer flush of process-space entries
  output logic tb_flush_process,
  output logic [31:0] ctx_phys_addr
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_HALT} state_t;

  typedef struct packed {
    state_t st;
    logic [31:0] vtb;
    logic [31:0] ctx;
    logic [31:0] psw;
    logic pa30;
    logic mchk_busy;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vfetch_req;
    logic [31:0] vfetch_addr;
    logic is_exc;
    logic [4:0] prio;
    logic [3:0] npar;
    logic force_is;
    logic same_mode;
    logic fpd;
    logic disp_valid;
    logic [31:0] disp_pc;
    logic disp_is;
    logic disp_same;
    logic disp_fpd;
    logic [4:0] disp_prio;
    logic [3:0] disp_npar;
    logic halt;
    logic [5:0] halt_code;
    logic tb_flush;
    logic busy;
    logic [31:0] ctx_phys;
  } state_s_t;

  state_s_t s_q, s_d;

  ////////////////////////////////////////////////////////////////////////
  // combinational next state

  logic [2:0] mode_entry;
  logic [2:0] mode_ret;
  logic on_intstk;
  logic [8:0] ev_off;
  logic [3:0] ev_npar;
  logic ev_force_is;
  logic ev_same;
  logic ev_fpd;
  logic [4:0] ev_prio;
  logic [31:0] rd_val;
  logic rd_ok;
  logic apb_wr;
  logic apb_rd;

  assign mode_entry = s_q.psw[PSW_MODE_LO+2:PSW_MODE_LO];
  assign mode_ret = ret_psw[PSW_MODE_LO+2:PSW_MODE_LO];
  assign on_intstk = s_q.psw[PSW_MODE_LO+2];
  assign apb_wr = psel && penable && pwrite && !s_q.pready;
  assign apb_rd = psel && penable && !pwrite && !s_q.pready;

  // event decode into vector slot, parameter count and priority
  always_comb begin
    ev_off = VEC_PASSIVE;
    ev_npar = NPAR_NONE;
    ev_force_is = 1'b0;
    ev_same = 1'b0;
    ev_fpd = 1'b0;
    ev_prio = s_q.psw[20:16];
    case (ev_kind)
      EV_PASSIVE: begin
        ev_off = VEC_PASSIVE;
        ev_prio = ev_req_prio;
      end
      EV_MCHK: begin
        ev_off = VEC_MCHK;
        ev_npar = NPAR_MCHK;
        ev_force_is = 1'b1;
      end
      EV_KSNV: begin
        ev_off = VEC_KSNV;
        ev_force_is = 1'b1;
      end
      EV_PWRFAIL: begin
        ev_off = VEC_PWRFAIL;
        ev_prio = PRIO_PWRFAIL;
      end
      EV_ACV: begin
        ev_off = VEC_ACV;
        ev_npar = NPAR_FAULT;
      end
      EV_TNV: begin
        ev_off = VEC_TNV;
        ev_npar = NPAR_FAULT;
      end
      EV_ARITH: begin
        ev_off = VEC_ARITH;
        ev_npar = NPAR_ONE;
      end
      EV_CHM: begin
        ev_off = VEC_CHM + {5'h00, ev_chm_sel, 2'b00};
        ev_npar = NPAR_ONE;
      end
      EV_SOFT: begin
        // level 0 is not a real request; treated as level 1
        if (ev_level >= 4'd4) begin
          ev_off = VEC_SOFT4 + {3'b000, ev_level - 4'd4, 2'b00};
        end else if (ev_level == 4'd0) begin
          ev_off = VEC_SOFT1;
        end else begin
          ev_off = VEC_SOFT1 + {3'b000, ev_level - 4'd1, 2'b00};
        end
      end
      EV_EMUL_START: begin
        ev_off = VEC_EMUL_START;
        ev_npar = NPAR_EMUL;
        ev_same = 1'b1;
        ev_fpd = 1'b0;
      end
      EV_EMUL_CONT: begin
        ev_off = VEC_EMUL_CONT;
        ev_same = 1'b1;
        ev_fpd = 1'b1;
      end
      default: begin
        ev_off = VEC_PASSIVE;
      end
    endcase
  end

  // register read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (paddr)
      REG_VTB: rd_val = s_q.vtb;
      REG_CTX: rd_val = s_q.ctx;
      REG_CTRL: rd_val = {31'h0000_0000, s_q.pa30};
      REG_STAT: rd_val = {23'h00_0000, s_q.mchk_busy, s_q.halt_code, s_q.halt, s_q.st != ST_IDLE};
      REG_DISP: rd_val = {16'h0000, s_q.disp_npar, s_q.disp_prio, s_q.disp_fpd, s_q.disp_same, s_q.disp_is, 4'h0};
      REG_SRV: rd_val = s_q.disp_pc;
      REG_FETCH: rd_val = s_q.vfetch_addr;
      REG_PSW: rd_val = s_q.psw;
      // unmapped offsets read as zero and answer with an error
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.disp_valid = 1'b0;
    s_d.tb_flush = 1'b0;

    // apb: one wait state, answer on the second access cycle
    if (apb_rd) begin
      s_d.pready = 1'b1;
      s_d.prdata = rd_val;
      s_d.pslverr = !rd_ok;
    end
    if (apb_wr) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !rd_ok;
      case (paddr)
        REG_VTB: s_d.vtb = {pwdata[31:2], 2'b00};
        REG_CTX: s_d.ctx = pwdata;
        REG_CTRL: begin
          s_d.pa30 = pwdata[CTRL_PA30];
          if (pwdata[CTRL_HALT_ACK] && s_q.st == ST_HALT) begin
            s_d.st = ST_IDLE;
            s_d.halt = 1'b0;
          end
          // acknowledge ends machine check processing
          if (pwdata[CTRL_MCHK_ACK]) begin
            s_d.mchk_busy = 1'b0;
          end
        end
        REG_PSW: s_d.psw = pwdata;
        default: begin
        end
      endcase
    end

    case (s_q.st)
      ST_IDLE: begin
        if (ret_valid) begin
          if (mode_ret >= PSW_MODE_BAD) begin
            s_d.st = ST_HALT;
            s_d.halt = 1'b1;
            s_d.halt_code = HC_RETURN_101 + {4'h0, mode_ret[1:0]} - 6'h01;
          end else begin
            s_d.psw = ret_psw;
          end
        end else if (ldctx_valid) begin
          s_d.tb_flush = 1'b1;
        end else if (ev_valid) begin
          if (mode_entry >= PSW_MODE_BAD) begin
            s_d.st = ST_HALT;
            s_d.halt = 1'b1;
            s_d.halt_code = HC_ENTRY_101 + {4'h0, mode_entry[1:0]} - 6'h01;
          end else if (ev_kind == EV_MCHK && s_q.mchk_busy) begin
            s_d.st = ST_HALT;
            s_d.halt = 1'b1;
            s_d.halt_code = HC_NESTED_MCHK;
          end else begin
            s_d.st = ST_FETCH;
            s_d.vfetch_req = 1'b1;
            s_d.vfetch_addr = s_q.vtb + {23'h00_0000, ev_off};
            s_d.is_exc = ev_is_exception;
            s_d.prio = ev_prio;
            s_d.npar = ev_npar;
            s_d.force_is = ev_force_is;
            s_d.same_mode = ev_same;
            s_d.fpd = ev_fpd;
            if (ev_kind == EV_MCHK) begin
              s_d.mchk_busy = 1'b1;
            end
          end
        end
      end
      ST_FETCH: begin
        if (vfetch_ack) begin
          s_d.vfetch_req = 1'b0;
          if (vfetch_data[1]) begin
            s_d.st = ST_HALT;
            s_d.halt = 1'b1;
            s_d.halt_code = vfetch_data[0] ? HC_ILLVEC : HC_WCSVEC;
          end else begin
            s_d.st = ST_IDLE;
            s_d.disp_valid = 1'b1;
            s_d.disp_pc = {vfetch_data[31:2], 2'b00};
            s_d.disp_npar = s_q.npar;
            s_d.disp_same = s_q.same_mode;
            s_d.disp_fpd = s_q.fpd;
            s_d.disp_prio = s_q.prio;
            if (vfetch_data[1:0] == VC_INTSTK) begin
              s_d.disp_is = 1'b1;
              if (s_q.is_exc) begin
                s_d.disp_prio = PRIO_HIGH;
              end
            end else begin
              // code 00: kernel stack unless already on interrupt stack or forced for machine check and kernel stack invalid
              s_d.disp_is = s_q.force_is || on_intstk;
            end
            s_d.psw[20:16] = s_d.disp_prio;
            s_d.psw[PSW_MODE_LO+2] = s_d.disp_is;
          end
        end
      end
      ST_HALT: begin
        // held until software acknowledges through the control register
        s_d.vfetch_req = 1'b0;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // registered copies so that every port comes straight off a flop
    s_d.busy = s_d.st != ST_IDLE;
    // upper bits forced to zero rather than wrapped into low memory
    s_d.ctx_phys = s_d.pa30 ? {2'b00, s_d.ctx[29:0]} : s_d.ctx;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign vfetch_req = s_q.vfetch_req;
  assign vfetch_addr = s_q.vfetch_addr;
  assign disp_valid = s_q.disp_valid;
  assign disp_pc = s_q.disp_pc;
  assign disp_on_intstk = s_q.disp_is;
  assign disp_same_mode = s_q.disp_same;
  assign disp_fpd = s_q.disp_fpd;
  assign disp_prio = s_q.disp_prio;
  assign disp_nparams = s_q.disp_npar;
  assign disp_psw = s_q.psw;
  assign busy = s_q.busy;
  assign halt = s_q.halt;
  assign halt_code = s_q.halt_code;
  assign tb_flush_process = s_q.tb_flush;
  // upper bits dropped in 30-bit mode
  assign ctx_phys_addr = s_q.ctx_phys;

endmodule

// ---- inc/scb_dispatch_pkg.sv ----
// constants and types shared by the exception dispatch block
package scb_dispatch_pkg;
  // register map over apb (byte addresses)
  localparam logic [7:0] REG_VTB = 8'h00;   // vector_table_base, internal reg 17
  localparam logic [7:0] REG_CTX = 8'h04;   // process_context_base, internal reg 16
  localparam logic [7:0] REG_CTRL = 8'h08;  // control: addressing mode, halt ack
  localparam logic [7:0] REG_STAT = 8'h0c;  // status: halt, halt code, machine check busy
  localparam logic [7:0] REG_DISP = 8'h10;  // last dispatch: stack, priority, params
  localparam logic [7:0] REG_SRV = 8'h14;   // last service routine address
  localparam logic [7:0] REG_FETCH = 8'h18; // last vector fetch address
  localparam logic [7:0] REG_PSW = 8'h1c;   // processor_status_word
  localparam logic [4:0] IPR_VTB = 5'h11;
  localparam logic [4:0] IPR_CTX = 5'h10;
  // control bits
  localparam int CTRL_PA30 = 0;
  localparam int CTRL_HALT_ACK = 1;
  localparam int CTRL_MCHK_ACK = 2;
  // vector offsets
  localparam logic [8:0] VEC_PASSIVE = 9'h000;
  localparam logic [8:0] VEC_MCHK = 9'h004;
  localparam logic [8:0] VEC_KSNV = 9'h008;
  localparam logic [8:0] VEC_PWRFAIL = 9'h00c;
  localparam logic [8:0] VEC_ACV = 9'h020;
  localparam logic [8:0] VEC_TNV = 9'h024;
  localparam logic [8:0] VEC_ARITH = 9'h034;
  localparam logic [8:0] VEC_CHM = 9'h040;
  localparam logic [8:0] VEC_SOFT1 = 9'h084;
  localparam logic [8:0] VEC_SOFT4 = 9'h090;
  localparam logic [8:0] VEC_EMUL_START = 9'h0c8;
  localparam logic [8:0] VEC_EMUL_CONT = 9'h0cc;
  // parameter counts
  localparam logic [3:0] NPAR_MCHK = 4'd6;
  localparam logic [3:0] NPAR_FAULT = 4'd2;
  localparam logic [3:0] NPAR_ONE = 4'd1;
  localparam logic [3:0] NPAR_EMUL = 4'd10;
  localparam logic [3:0] NPAR_NONE = 4'd0;
  // priority levels
  localparam logic [4:0] PRIO_HIGH = 5'h1f;
  localparam logic [4:0] PRIO_PWRFAIL = 5'h1e;
  // console halt codes
  localparam logic [5:0] HC_ILLVEC = 6'h07;
  localparam logic [5:0] HC_WCSVEC = 6'h08;
  localparam logic [5:0] HC_NESTED_MCHK = 6'h12;
  localparam logic [5:0] HC_ENTRY_101 = 6'h19;
  localparam logic [5:0] HC_RETURN_101 = 6'h1d;
  // vector codes (low two bits)
  localparam logic [1:0] VC_KERNEL = 2'b00;
  localparam logic [1:0] VC_INTSTK = 2'b01;
  localparam logic [1:0] VC_WCS = 2'b10;
  // status word mode field position
  localparam int PSW_MODE_LO = 24;
  localparam logic [2:0] PSW_MODE_BAD = 3'b101;
  // event kinds
  typedef enum logic [3:0] {
    EV_PASSIVE, EV_MCHK, EV_KSNV, EV_PWRFAIL, EV_ACV, EV_TNV, EV_ARITH,
    EV_CHM, EV_SOFT, EV_EMUL_START, EV_EMUL_CONT, EV_OTHER
  } event_kind_t;
endpackage

// ---- tb/scb_exception_dispatch_checker.sv ----
// port assertions for the exception dispatch block
`timescale 1ns/100ps
module scb_exception_dispatch_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic ev_valid,
  input wire logic ret_valid,
  input wire logic [31:0] ret_psw,
  input wire logic ldctx_valid,
  input wire logic vfetch_req,
  input wire logic [31:0] vfetch_addr,
  input wire logic vfetch_ack,
  input wire logic [31:0] vfetch_data,
  input wire logic disp_valid,
  input wire logic [31:0] disp_pc,
  input wire logic disp_on_intstk,
  input wire logic busy,
  input wire logic halt,
  input wire logic [5:0] halt_code,
  input wire logic tb_flush_process
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic idle;
  assign idle = !busy && !halt;
  ////////////////////////////////////////////////////////////////
  sequence s_take;
    ev_valid && idle && !ret_valid && !ldctx_valid;
  endsequence
  sequence s_ack(c);
    vfetch_req && vfetch_ack && vfetch_data[1:0] == c;
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_event_fetch: assert property (s_take |=> (vfetch_req && vfetch_addr[1:0] == 2'h0) || halt)
    else $error("no aligned vector fetch after event");
  chk_fetch_holds: assert property (vfetch_req && !vfetch_ack |=> vfetch_req && $stable(vfetch_addr))
    else $error("vector fetch dropped or moved");
  chk_kernel_dispatch: assert property (s_ack(2'h0) |=> disp_valid && disp_pc == ($past(vfetch_data) & 32'hffff_fffc))
    else $error("service address not taken from vector");
  chk_intstk_dispatch: assert property (s_ack(2'h1) |=> disp_valid && disp_on_intstk)
    else $error("code 01 not on interrupt stack");
  chk_bad_code_halt: assert property (vfetch_req && vfetch_ack && vfetch_data[1] |=> halt && !disp_valid)
    else $error("unimplemented vector code dispatched");
  chk_return_mode_halt: assert property (ret_valid && idle && ret_psw[26:24] > 3'h4
    |=> halt && {26'h0, halt_code} == 32'h18 + (($past(ret_psw) >> 24) & 32'h7))
    else $error("bad restored mode without right halt");
  chk_halt_holds: assert property (halt && !(psel && penable && pwrite) |=> halt && $stable(halt_code))
    else $error("halt left without acknowledge");
  chk_flush_pulse: assert property (ldctx_valid && idle && !ret_valid |=> tb_flush_process ##1 !tb_flush_process)
    else $error("context load without one flush pulse");
endmodule
bind scb_exception_dispatch scb_exception_dispatch_checker chk (.*);

// ---- tb/scb_exception_dispatch_tb.sv ----
// self-checking bench for the exception dispatch block
`timescale 1ns/100ps
module scb_exception_dispatch_tb
  import scb_dispatch_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ev_valid = 0, ev_is_exception = 0, ret_valid = 0, ldctx_valid = 0, vfetch_ack = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, ret_psw = 32'h0, vfetch_data = 32'hffff_ffff;
  event_kind_t ev_kind = EV_PASSIVE;
  logic [4:0] ev_req_prio = 5'h00, disp_prio, rip;
  logic [3:0] ev_level = 4'h1, disp_nparams;
  logic [1:0] ev_chm_sel = 2'h0;
  logic [31:0] prdata, vfetch_addr, disp_pc, disp_psw, ctx_phys_addr, base, rd, vec;
  logic pready, pslverr, vfetch_req, disp_valid, disp_on_intstk, disp_same_mode, disp_fpd;
  logic busy, halt, tb_flush_process, err, dv;
  logic [5:0] halt_code;
  int fails = 0, check_count = 0;
  always #2 pclk = ~pclk;
  scb_exception_dispatch dut (.*);
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo();
    cmp(32'h0, 32'h1);
    print_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1 && n < 20);
    if (n >= 20) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] voff(input event_kind_t k, input logic [3:0] lv, input logic [1:0] s);
    case (k)
      EV_MCHK: return 32'h04;
      EV_KSNV: return 32'h08;
      EV_PWRFAIL: return 32'h0c;
      EV_ACV: return 32'h20;
      EV_TNV: return 32'h24;
      EV_ARITH: return 32'h34;
      EV_CHM: return 32'h40 + 4 * s;
      EV_SOFT: return 32'h80 + 4 * lv;
      EV_EMUL_START: return 32'hc8;
      EV_EMUL_CONT: return 32'hcc;
      default: return 32'h00;
    endcase
  endfunction
  function automatic logic [3:0] np(input event_kind_t k);
    case (k)
      EV_MCHK: return 4'h6;
      EV_ACV, EV_TNV: return 4'h2;
      EV_ARITH, EV_CHM: return 4'h1;
      EV_EMUL_START: return 4'ha;
      default: return 4'h0;
    endcase
  endfunction
  // returns after the dispatch pulse or a halt; dv keeps the one-cycle pulse
  task automatic ev(input event_kind_t k, input logic [3:0] lv, input logic [1:0] s,
                    input logic ex, input logic [31:0] v);
    int n;
    dv = 0;
    @(posedge pclk);
    ev_valid <= 1;
    ev_kind <= k;
    ev_level <= lv;
    ev_chm_sel <= s;
    ev_is_exception <= ex;
    ev_req_prio <= rip;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (vfetch_req !== 1 && halt !== 1 && n < 20);
    ev_valid <= 0;
    if (n >= 20) tmo();
    if (vfetch_req === 1) begin
      cmp(vfetch_addr, base + voff(k, lv, s));
      cmp(busy, 1);
      vfetch_ack <= 1;
      vfetch_data <= v;
      @(posedge pclk);
      vfetch_ack <= 0;
      vfetch_data <= ~v; // released bus must not look valid
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (disp_valid !== 1 && halt !== 1 && n < 20);
      if (n >= 20) tmo();
      dv = disp_valid;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int i, m;
    event_kind_t k;
    logic [3:0] lv;
    logic [1:0] s;
    logic ex;
    rd = $urandom(75);
    rip = 5'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    base = $urandom;
    apb(1, REG_VTB, base);
    apb(0, REG_VTB, 32'h0);
    base[1:0] = 2'h0;
    cmp(rd, base);
    apb(0, 8'h20, 32'h0);
    cmp(err, 1);
    vec = $urandom;
    apb(1, REG_CTX, vec);
    apb(1, REG_CTRL, 32'h1);
    cmp(ctx_phys_addr, {2'h0, vec[29:0]});
    apb(1, REG_CTRL, 32'h0);
    cmp(ctx_phys_addr, vec);
    @(posedge pclk);
    ldctx_valid <= 1;
    @(posedge pclk);
    ldctx_valid <= 0;
    @(posedge pclk);
    cmp(tb_flush_process, 1);
    // every kind except EV_OTHER, all fifteen soft levels and all four mode traps
    for (i = 0; i < 30; i++) begin
      k = i < 11 ? event_kind_t'(i) : i < 26 ? EV_SOFT : EV_CHM;
      lv = 4'(i - 10);
      s = 2'(i - 26);
      ex = !(k inside {EV_PASSIVE, EV_PWRFAIL, EV_SOFT});
      rip = 5'($urandom);
      vec = $urandom;
      vec[1] = 0;
      apb(1, REG_PSW, 32'h0);
      ev(k, lv, s, ex, vec);
      cmp(dv, 1);
      cmp(disp_pc, {vec[31:2], 2'h0});
      cmp(disp_on_intstk, vec[0] || k inside {EV_MCHK, EV_KSNV});
      cmp(disp_nparams, np(k));
      if (k == EV_PASSIVE) cmp(disp_prio, rip);
      else if (k == EV_PWRFAIL) cmp(disp_prio, 5'h1e);
      else if (vec[0] && ex) cmp(disp_prio, 5'h1f);
      if (k inside {EV_EMUL_START, EV_EMUL_CONT}) begin
        cmp({disp_same_mode, disp_fpd}, {1'b1, k == EV_EMUL_CONT});
      end
    end
    // machine check still unacknowledged from the loop above
    ev(EV_MCHK, 4'h1, 2'h0, 1, 32'h1);
    cmp({dv, halt, halt_code}, {2'h1, 6'h12});
    apb(1, REG_CTRL, 32'h6);
    cmp(halt, 0);
    ev(EV_MCHK, 4'h1, 2'h0, 1, 32'h1);
    cmp(dv, 1);
    apb(1, REG_CTRL, 32'h4);
    for (i = 2; i < 4; i++) begin
      vec = $urandom;
      vec[1:0] = 2'(i);
      ev(EV_ARITH, 4'h1, 2'h0, 1, vec);
      cmp({dv, halt_code}, i == 2 ? 7'h08 : 7'h07);
      apb(1, REG_CTRL, 32'h2);
      cmp(halt, 0);
    end
    for (m = 3; m < 8; m++) begin
      apb(1, REG_PSW, 32'(m) << 24);
      ev(EV_ACV, 4'h1, 2'h0, 1, 32'h100);
      if (m > 4) cmp({halt, halt_code}, 7'h40 + 7'h14 + 7'(m));
      else cmp(disp_on_intstk, m >> 2);
      apb(1, REG_CTRL, 32'h2);
      @(posedge pclk);
      ret_valid <= 1;
      ret_psw <= (32'(m) << 24) | (32'(m) << 16);
      @(posedge pclk);
      ret_valid <= 0;
      @(posedge pclk);
      if (m > 4) cmp({halt, halt_code}, 7'h40 + 7'h18 + 7'(m));
      else cmp(disp_psw, (32'(m) << 24) | (32'(m) << 16));
      apb(1, REG_CTRL, 32'h2);
    end
    print_verdict();
  end
endmodule
